// ---- core/usbn_consts.vh ----
// usbn_consts.vh: register map, field positions and timing counts
// assumes a 10 MHz clk_i and a 32-bit classic wishbone register bus
// What this block does
// [RULE_01] node is always in exactly one of four states
// [RULE_02] suspend, resume, reset line conditions logged in alternate events
// [RULE_03] bus activity while suspended from idle pulses the wake-up output
// [RULE_04] three milliseconds without bus activity sets the suspend-detect flag
// [RULE_05] software answers suspend-detect by writing the suspended state
// [RULE_06] software guarantees five milliseconds idle before remote wake-up
// [RULE_07] resuming state drives K for between one and five milliseconds
// [RULE_08] host resumes twenty milliseconds; software sets operational for end
// [RULE_09] no end-of-packet within hundred milliseconds, software resumes again
// [RULE_10] while suspended, resume or reset from host can interrupt
// [RULE_11] node and software answer tokens within ten milliseconds
// [RULE_12] token address matched to function address, then endpoints in parallel
// [RULE_13] one 8-byte control fifo, three 64-byte transmit, three receive
// [RULE_14] transmit fifos on pipes 1, 3, 5; receive on 2, 4, 6
// [RULE_15] each fifo has one endpoint number; one shared function address
// [RULE_16] software never enables both directions of endpoint zero
// [RULE_17] same-direction endpoint clash goes to lowest enabled eligible pipe
// [RULE_18] opposite-direction pipes with equal endpoint are independent
// [RULE_19] control fifo takes default-address traffic when its bit is set
// [RULE_20] control endpoint no isochronous; holds one packet of eight bytes
// [RULE_21] loaded control packet sent on in token; kept and resent on error
// [RULE_22] control fifo flush empties it for out packet or reload
// [RULE_23] out data reported only without crc or stuff error; bad discarded
// [RULE_24] module enable clear stops clock, resets registers, forces SE0
// [RULE_25] inactivity timer restarts at every bus transition
`ifndef USBN_CONSTS_VH
`define USBN_CONSTS_VH
`define USBN_CLK_KHZ    16'h2710
`define USBN_SUSP_MS    16'h0003
`define USBN_RES_K_MS   16'h0002
`define USBN_RST_NS     2500
`define USBN_RST_CYC    ((`USBN_RST_NS * `USBN_CLK_KHZ + 999999) / 1000000)
`define USBN_A_MAIN     6'h00
`define USBN_A_NODE_FUNCTIONAL_STATE_REGISTER     6'h01
`define USBN_A_ALTERNATE_EVENT_REGISTER    6'h02
`define USBN_A_ALTMSK   6'h03
`define USBN_A_FUNCTION_ADDRESS_REGISTER     6'h04
`define USBN_A_EP0C     6'h05
`define USBN_A_EP0S     6'h06
`define USBN_A_EP0D     6'h07
`define USBN_SUB_CTL    2'h0
`define USBN_SUB_STAT   2'h1
`define USBN_SUB_DATA   2'h2
`define USBN_MAIN_EN    0
`define USBN_EV_SUSP    0
`define USBN_EV_RES     1
`define USBN_EV_RST     2
`define USBN_E0_TXEN    0
`define USBN_E0_RXEN    1
`define USBN_E0_DEF     2
`define USBN_E0_FLUSH   3
`define USBN_E0_LOAD    4
`define USBN_PC_EN      4
`define USBN_PC_ISO     5
`define USBN_PC_FLUSH   6
`define USBN_PS_DONE    7
`define USBN_PID_OUT    2'h0
`define USBN_PID_IN     2'h1
`define USBN_PID_SETUP  2'h2
`define USBN_LS_J       2'h2
`define USBN_LS_K       2'h1
`define USBN_LS_SE0     2'h0
`endif

// ---- core/usbn_node.v ----
// usbn_node.v: usb 1.1 node line states, address decode and endpoint fifos
// assumes an outside serial engine delivering decoded tokens, payload
// bytes and packet end status, all synchronous to clk_i
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "usbn_consts.vh"

module usbn_node #(
	parameter [15:0] SUSP_CYC  = `USBN_SUSP_MS * `USBN_CLK_KHZ,
	parameter [15:0] RES_K_CYC = `USBN_RES_K_MS * `USBN_CLK_KHZ
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o,
	output wire        irq_o,
	output wire        wakeup_o,
	output wire        clk48_run_o,
	input  wire        dp_i,
	input  wire        dm_i,
	output wire        dp_o,
	output wire        dm_o,
	output wire        line_oe_n_o,
	input  wire        tok_valid_i,
	input  wire [1:0]  tok_pid_i,
	input  wire [10:0] tok_bits_i,
	output wire        tok_hit_o,
	input  wire        rx_byte_valid_i,
	input  wire [7:0]  rx_byte_i,
	input  wire        rx_end_i,
	input  wire        rx_err_i,
	input  wire        tx_req_i,
	output wire [7:0]  tx_byte_o,
	output wire        tx_vld_o,
	output wire        tx_none_o,
	input  wire        tx_end_i,
	input  wire        tx_ok_i
);

	localparam [1:0] ST_OPER   = 2'd0;
	localparam [1:0] ST_SUSP   = 2'd1;
	localparam [1:0] ST_RESUME = 2'd2;
	localparam [1:0] ST_RESET  = 2'd3;
	localparam [31:0] RST_CYC_W = `USBN_RST_CYC;
	localparam [15:0] RST_CYC  = RST_CYC_W[15:0];

	reg        ack_r;
	reg [31:0] dat_r;
	reg [31:0] rd_mux;
	reg        enable_r;
	reg [1:0]  state_r;
	reg [2:0]  alt_ev_r;
	reg [2:0]  alt_msk_r;
	reg [6:0]  function_address_register_r;
	reg        irq_r;
	reg        wake_r;
	reg [1:0]  line_r;
	reg [15:0] idle_cnt_r;
	reg [15:0] se0_cnt_r;
	reg [15:0] k_cnt_r;
	reg        dp_r;
	reg        dm_r;
	reg        oe_n_r;
	reg [2:0]  e0_ctl_r;
	reg        e0_rdy_r;
	reg        e0_outf_r;
	reg        e0_indone_r;
	reg        e0_ovf_r;
	reg [3:0]  e0_cnt_r;
	reg [3:0]  e0_rd_r;
	reg [7:0]  e0_mem [0:7];
	reg        act_r;
	reg        act_in_r;
	reg [2:0]  cur_p_r;
	reg [7:0]  tx_byte_r;
	reg        tx_vld_r;
	reg        tx_none_r;
	reg        hit;
	reg [2:0]  sel_p;
	reg [2:0]  alt_set;
	integer    i;
	integer    j;

	wire        nrst    = rst_i | ~enable_r; // [RULE_24]
	wire        bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
	wire        bus_wr  = bus_req & wb_we_i & wb_sel_i[0] & enable_r;
	wire        bus_rd  = bus_req & ~wb_we_i & enable_r;
	wire [5:0]  widx    = wb_adr_i[7:2];
	wire [1:0]  ls      = {dp_i, dm_i};
	wire        activity = (ls != line_r);
	wire [6:0]  tok_adr = tok_bits_i[6:0];
	wire [3:0]  tok_ep  = tok_bits_i[10:7];
	wire        is_in   = (tok_pid_i == `USBN_PID_IN);
	wire        adr_ok  = (tok_adr == function_address_register_r); // [RULE_12]
	wire        def_ok  = e0_ctl_r[`USBN_E0_DEF] & (tok_adr == 7'h00); // [RULE_19]
	wire        e0_mine = act_r & (cur_p_r == 3'd0);
	wire [2:0]  ci      = cur_p_r - 3'd1;
	wire [5:0]  p_elig;
	wire [47:0] p_head;
	wire [47:0] p_stat;
	wire [47:0] p_ctl;

	// endpoint zero: no iso, one packet, never both directions at once
	wire e0_elig = (adr_ok | def_ok) & (tok_ep == 4'h0) &
		(is_in ? (e0_ctl_r[`USBN_E0_TXEN] & e0_rdy_r) :
		(e0_ctl_r[`USBN_E0_RXEN] & ~e0_outf_r & ~e0_rdy_r)); // [RULE_20]

	// lowest eligible pipe wins; ep0 checked last so it has priority
	always @* begin
		hit = 1'b0;
		sel_p = 3'd0;
		for (i = 5; i >= 0; i = i - 1) begin
			if (adr_ok && p_elig[i]) begin // [RULE_17]
				hit = 1'b1;
				sel_p = i[2:0] + 3'd1;
			end
		end
		if (e0_elig) begin
			hit = 1'b1;
			sel_p = 3'd0;
		end
	end

	// six data pipes: even index transmits, odd index receives
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : pipe
			localparam       IS_TX = (g % 2 == 0); // [RULE_14]
			localparam [31:0] SLOT_W = g + 2;
			localparam [31:0] MY_P_W = g + 1;
			localparam [3:0] SLOT  = SLOT_W[3:0];
			localparam [2:0] MY_P  = MY_P_W[2:0];
			reg [7:0] mem [0:63]; // [RULE_13]
			reg [6:0] wp_r;
			reg [6:0] rp_r;
			reg [6:0] st_r;
			reg [3:0] ep_r;
			reg       en_r;
			reg       iso_r;
			reg       done_r;
			wire [6:0] cnt   = wp_r - rp_r;
			wire       full  = cnt[6];
			wire       empty = (cnt == 7'h00);
			wire       mine  = act_r & (cur_p_r == MY_P);
			wire       bsel  = (wb_adr_i[7:4] == SLOT);
			wire       b_dat = bsel & (wb_adr_i[3:2] == `USBN_SUB_DATA);
			wire       b_ctl = bus_wr & bsel &
				(wb_adr_i[3:2] == `USBN_SUB_CTL);
			wire       b_st  = bus_wr & bsel &
				(wb_adr_i[3:2] == `USBN_SUB_STAT);
			wire       wr_en = IS_TX ? (bus_wr & b_dat) :
				(mine & rx_byte_valid_i);
			wire [7:0] wr_d  = IS_TX ? wb_dat_i[7:0] : rx_byte_i;
			wire       rd_en = IS_TX ? (mine & tx_req_i) :
				(bus_rd & b_dat);
			wire       pdone = mine & ((rx_end_i & ~rx_err_i) |
				(tx_end_i & tx_ok_i));
			// iso pipes hand over once full or empty
			assign p_elig[g] = en_r & (ep_r == tok_ep) & (IS_TX == is_in) &
				(~iso_r | (IS_TX ? ~empty : ~full)); // [RULE_15] [RULE_18]
			assign p_head[g*8 +: 8] = mem[rp_r[5:0]];
			assign p_stat[g*8 +: 8] = {done_r, cnt};
			assign p_ctl[g*8 +: 8]  = {2'b00, iso_r, en_r, ep_r};
			always @(posedge clk_i) begin
				if (wr_en && !full)
					mem[wp_r[5:0]] <= wr_d;
			end
			always @(posedge clk_i) begin
				if (nrst) begin
					wp_r <= 7'h00;
					rp_r <= 7'h00;
					st_r <= 7'h00;
					ep_r <= 4'h0;
					en_r <= 1'b0;
					iso_r <= 1'b0;
					done_r <= 1'b0;
				end else begin
					if (wr_en && !full)
						wp_r <= wp_r + 7'h01;
					if (rd_en && !empty)
						rp_r <= rp_r + 7'h01;
					if (tok_valid_i && hit && sel_p == MY_P)
						st_r <= wp_r;
					if (!IS_TX && mine && rx_end_i && rx_err_i)
						wp_r <= st_r; // [RULE_23]
					if (b_ctl) begin
						ep_r <= wb_dat_i[3:0];
						en_r <= wb_dat_i[`USBN_PC_EN];
						iso_r <= wb_dat_i[`USBN_PC_ISO];
						if (wb_dat_i[`USBN_PC_FLUSH]) begin
							wp_r <= 7'h00;
							rp_r <= 7'h00;
						end
					end
					// set wins over a same-cycle clear
					done_r <= pdone |
						(done_r & ~(b_st & wb_dat_i[`USBN_PS_DONE]));
				end
			end
		end
	endgenerate

	// register read mux
	always @* begin
		rd_mux = 32'h0000_0000;
		case (widx)
		`USBN_A_MAIN:   rd_mux[0] = enable_r;
		`USBN_A_NODE_FUNCTIONAL_STATE_REGISTER:   rd_mux[1:0] = state_r;
		`USBN_A_ALTERNATE_EVENT_REGISTER:  rd_mux[2:0] = alt_ev_r;
		`USBN_A_ALTMSK: rd_mux[2:0] = alt_msk_r;
		`USBN_A_FUNCTION_ADDRESS_REGISTER:   rd_mux[6:0] = function_address_register_r;
		`USBN_A_EP0C:   rd_mux[2:0] = e0_ctl_r;
		`USBN_A_EP0S:   rd_mux[7:0] = {e0_cnt_r, 1'b0, e0_rdy_r,
			e0_indone_r, e0_outf_r};
		`USBN_A_EP0D:   rd_mux[7:0] = e0_mem[e0_rd_r[2:0]];
		default: begin
			for (j = 0; j < 6; j = j + 1) begin
				if (wb_adr_i[7:4] == j[3:0] + 4'h2) begin
					case (wb_adr_i[3:2])
					`USBN_SUB_CTL:  rd_mux[7:0] = p_ctl[j*8 +: 8];
					`USBN_SUB_STAT: rd_mux[7:0] = p_stat[j*8 +: 8];
					`USBN_SUB_DATA: rd_mux[7:0] = p_head[j*8 +: 8];
					default:        rd_mux[7:0] = 8'h00;
					endcase
				end
			end
		end
		endcase
	end

	// bus slave and module enable, outside the node reset
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
			enable_r <= 1'b0;
		end else begin
			ack_r <= bus_req;
			if (bus_req)
				dat_r <= enable_r ? rd_mux :
					{31'h0000_0000, 1'b0};
			if (bus_req && wb_we_i && wb_sel_i[0] &&
				widx == `USBN_A_MAIN)
				enable_r <= wb_dat_i[`USBN_MAIN_EN];
		end
	end

	// line condition events
	always @* begin
		alt_set = 3'b000;
		if (idle_cnt_r == SUSP_CYC - 16'h0001 && !activity)
			alt_set[`USBN_EV_SUSP] = 1'b1; // [RULE_04]
		if (state_r == ST_SUSP && activity && ls == `USBN_LS_K)
			alt_set[`USBN_EV_RES] = 1'b1; // [RULE_10]
		if (se0_cnt_r == RST_CYC - 16'h0001 && ls == `USBN_LS_SE0)
			alt_set[`USBN_EV_RST] = 1'b1;
	end

	// node state, line detection and drive
	always @(posedge clk_i) begin
		if (nrst) begin
			state_r <= ST_OPER;
			alt_ev_r <= 3'b000;
			alt_msk_r <= 3'b000;
			function_address_register_r <= 7'h00;
			irq_r <= 1'b0;
			wake_r <= 1'b0;
			line_r <= `USBN_LS_J;
			idle_cnt_r <= 16'h0000;
			se0_cnt_r <= 16'h0000;
			k_cnt_r <= 16'h0000;
			dp_r <= 1'b0;
			dm_r <= 1'b0;
			oe_n_r <= 1'b0; // [RULE_24]
		end else begin
			line_r <= ls;
			if (activity)
				idle_cnt_r <= 16'h0000; // [RULE_25]
			else if (idle_cnt_r != SUSP_CYC)
				idle_cnt_r <= idle_cnt_r + 16'h0001;
			if (ls != `USBN_LS_SE0)
				se0_cnt_r <= 16'h0000;
			else if (se0_cnt_r != RST_CYC)
				se0_cnt_r <= se0_cnt_r + 16'h0001;
			wake_r <= (state_r == ST_SUSP) && activity &&
				(line_r == `USBN_LS_J); // [RULE_03]
			alt_ev_r <= alt_set | (alt_ev_r &
				~((bus_wr && widx == `USBN_A_ALTERNATE_EVENT_REGISTER) ?
				wb_dat_i[2:0] : 3'b000)); // [RULE_02]
			irq_r <= |(alt_ev_r & alt_msk_r);
			if (bus_wr && widx == `USBN_A_ALTMSK)
				alt_msk_r <= wb_dat_i[2:0];
			if (bus_wr && widx == `USBN_A_FUNCTION_ADDRESS_REGISTER)
				function_address_register_r <= wb_dat_i[6:0];
			if (bus_wr && widx == `USBN_A_NODE_FUNCTIONAL_STATE_REGISTER) begin
				case (wb_dat_i[1:0]) // [RULE_01]
				ST_RESUME: begin
					if (state_r == ST_SUSP) begin
						state_r <= ST_RESUME;
						k_cnt_r <= RES_K_CYC; // [RULE_07]
					end
				end
				ST_OPER:  state_r <= ST_OPER; // [RULE_08]
				ST_SUSP:  state_r <= ST_SUSP;
				ST_RESET: state_r <= ST_RESET;
				default:  state_r <= state_r;
				endcase
			end else if (k_cnt_r != 16'h0000)
				k_cnt_r <= k_cnt_r - 16'h0001;
			if (alt_set[`USBN_EV_RST])
				state_r <= ST_RESET;
			dp_r <= 1'b0;
			dm_r <= (k_cnt_r != 16'h0000);
			oe_n_r <= (k_cnt_r == 16'h0000); // [RULE_07]
		end
	end

	// endpoint zero fifo and token tracking
	always @(posedge clk_i) begin
		if (bus_wr && widx == `USBN_A_EP0D && !e0_rdy_r &&
			!e0_cnt_r[3])
			e0_mem[e0_cnt_r[2:0]] <= wb_dat_i[7:0];
		else if (e0_mine && rx_byte_valid_i && !e0_cnt_r[3])
			e0_mem[e0_cnt_r[2:0]] <= rx_byte_i;
	end

	always @(posedge clk_i) begin
		if (nrst) begin
			e0_ctl_r <= 3'b000;
			e0_rdy_r <= 1'b0;
			e0_outf_r <= 1'b0;
			e0_indone_r <= 1'b0;
			e0_ovf_r <= 1'b0;
			e0_cnt_r <= 4'h0;
			e0_rd_r <= 4'h0;
			act_r <= 1'b0;
			act_in_r <= 1'b0;
			cur_p_r <= 3'd0;
			tx_byte_r <= 8'h00;
			tx_vld_r <= 1'b0;
			tx_none_r <= 1'b0;
		end else begin
			tx_vld_r <= 1'b0;
			tx_none_r <= 1'b0;
			if (tok_valid_i) begin
				act_r <= hit; // [RULE_12] [RULE_11]
				act_in_r <= is_in;
				cur_p_r <= sel_p;
				if (hit && sel_p == 3'd0 && !is_in) begin
					e0_cnt_r <= 4'h0;
					e0_ovf_r <= 1'b0;
				end
			end else if (act_r && (rx_end_i || tx_end_i))
				act_r <= 1'b0;
			if (bus_wr && widx == `USBN_A_EP0D && !e0_rdy_r &&
				!e0_cnt_r[3])
				e0_cnt_r <= e0_cnt_r + 4'h1;
			if (bus_rd && widx == `USBN_A_EP0D && e0_rd_r != e0_cnt_r)
				e0_rd_r <= e0_rd_r + 4'h1;
			if (e0_mine && !act_in_r && rx_byte_valid_i) begin
				if (e0_cnt_r[3])
					e0_ovf_r <= 1'b1;
				else
					e0_cnt_r <= e0_cnt_r + 4'h1;
			end
			if (e0_mine && !act_in_r && rx_end_i) begin
				if (rx_err_i || e0_ovf_r)
					e0_cnt_r <= 4'h0; // [RULE_23]
				else begin
					e0_outf_r <= 1'b1;
					e0_rd_r <= 4'h0;
				end
			end
			if (act_r && act_in_r && tx_req_i) begin
				if (e0_mine) begin
					if (e0_rd_r != e0_cnt_r) begin
						tx_byte_r <= e0_mem[e0_rd_r[2:0]];
						tx_vld_r <= 1'b1;
						e0_rd_r <= e0_rd_r + 4'h1;
					end else
						tx_none_r <= 1'b1;
				end else if (p_stat[ci*8 +: 7] != 7'h00) begin
					tx_byte_r <= p_head[ci*8 +: 8];
					tx_vld_r <= 1'b1;
				end else
					tx_none_r <= 1'b1;
			end
			if (e0_mine && act_in_r && tx_end_i) begin
				e0_rd_r <= 4'h0; // [RULE_21]
				if (tx_ok_i) begin
					e0_rdy_r <= 1'b0;
					e0_indone_r <= 1'b1;
				end
			end
			if (bus_wr && widx == `USBN_A_EP0S)
				e0_indone_r <= (e0_indone_r & ~wb_dat_i[1]) |
					(e0_mine && act_in_r && tx_end_i && tx_ok_i);
			if (bus_wr && widx == `USBN_A_EP0C) begin
				e0_ctl_r <= wb_dat_i[2:0];
				if (wb_dat_i[`USBN_E0_LOAD]) begin
					e0_rdy_r <= 1'b1;
					e0_rd_r <= 4'h0;
				end
				if (wb_dat_i[`USBN_E0_FLUSH]) begin // [RULE_22]
					e0_cnt_r <= 4'h0;
					e0_rd_r <= 4'h0;
					e0_rdy_r <= 1'b0;
					e0_outf_r <= 1'b0;
				end
			end
		end
	end

	assign wb_dat_o    = dat_r;
	assign wb_ack_o    = ack_r;
	assign irq_o       = irq_r;
	assign wakeup_o    = wake_r;
	assign clk48_run_o = enable_r; // [RULE_24]
	assign dp_o        = dp_r;
	assign dm_o        = dm_r;
	assign line_oe_n_o = oe_n_r;
	assign tok_hit_o   = act_r;
	assign tx_byte_o   = tx_byte_r;
	assign tx_vld_o    = tx_vld_r;
	assign tx_none_o   = tx_none_r;

endmodule // usbn_node

// ---- tb/tb_usbn_node.sv ----
// tb_usbn_node.sv: self-checking bench for the usb node
// assumes usbn_node, the host model and the checker are compiled first
`timescale 1ns/1ps
`include "usbn_consts.vh"

module tb_usbn_node;
	localparam int SUSP = 50;
	localparam int RESK = 20;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic ack, irq, wake, run, dpo, dmo, oen, hit, hit_o, txv, txn;
	logic [7:0] txb, rb;
	logic [10:0] tb;
	logic [1:0] tp;
	logic h_dp, h_dm, tv, rv, re, rr, tr, te, tk, err;
	logic [6:0] function_address_register;
	logic [3:0] e;
	integer seed = 32'h65154abd;
	int n_mismatch = 0, num_checks = 0, n_wake = 0, n;
	wire dp = oen ? h_dp : dpo;
	wire dm = oen ? h_dm : dmo;

	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) if (wake === 1'b1) n_wake <= n_wake + 1;

	usbn_node #(.SUSP_CYC(16'(SUSP)), .RES_K_CYC(16'(RESK))) usbn_node_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .wakeup_o(wake),
		.clk48_run_o(run), .dp_i(dp), .dm_i(dm), .dp_o(dpo), .dm_o(dmo),
		.line_oe_n_o(oen), .tok_valid_i(tv), .tok_pid_i(tp),
		.tok_bits_i(tb), .tok_hit_o(hit_o), .rx_byte_valid_i(rv),
		.rx_byte_i(rb), .rx_end_i(re), .rx_err_i(rr), .tx_req_i(tr),
		.tx_byte_o(txb), .tx_vld_o(txv), .tx_none_o(txn), .tx_end_i(te),
		.tx_ok_i(tk));
	usbn_host_mdl usbn_host_mdl_i (.clk_i(clk_i), .tok_hit_i(hit_o),
		.tx_byte_i(txb), .tx_vld_i(txv), .dp_o(h_dp), .dm_o(h_dm),
		.tok_valid_o(tv), .tok_pid_o(tp), .tok_bits_o(tb), .rx_vld_o(rv),
		.rx_byte_o(rb), .rx_end_o(re), .rx_err_o(rr), .tx_req_o(tr),
		.tx_end_o(te), .tx_ok_o(tk));

	function automatic logic [7:0] ra(input logic [5:0] w);
		return {w, 2'b00};
	endfunction
	function automatic logic [7:0] pa(input int p, input logic [7:0] o);
		return 8'h20 + 8'((p - 1) * 16) + o;
	endfunction
	function automatic logic [31:0] ep0_stat(input int c, input logic bad);
		return bad ? 32'h0 : {24'h0, 4'(c), 4'h1};
	endfunction

	task automatic report_and_stop();
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("wrong value t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic chk_pin(input logic [8:0] g, input logic [8:0] x);
		chk_reg({23'h0, g}, {23'h0, x});
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) chk_reg(32'h0, 32'h1);
		r = rdat;
		{cyc, stb, we} <= 3'b000;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x);
		wb(1'b0, a, 32'h0, q);
		chk_reg(q & m, x);
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk_pin({run, oen, dpo, dmo}, 9'h0);
		rd_chk(ra(`USBN_A_MAIN), '1, 32'h0);
		wr(ra(`USBN_A_MAIN), 32'h1);
		wr(ra(`USBN_A_ALTMSK), 32'h7);
		for (int i = 0; i < 4; i++) begin
			repeat (30) @(posedge clk_i);
			usbn_host_mdl_i.set_line(i[0] ? `USBN_LS_J : `USBN_LS_K);
		end
		rd_chk(ra(`USBN_A_ALTERNATE_EVENT_REGISTER), '1, 32'h0);
		repeat (SUSP + 5) @(posedge clk_i);
		rd_chk(ra(`USBN_A_ALTERNATE_EVENT_REGISTER), 32'h1, 32'h1);
		chk_pin({8'h0, irq}, 9'h1);
		wr(ra(`USBN_A_NODE_FUNCTIONAL_STATE_REGISTER), 32'h1);
		wr(ra(`USBN_A_ALTERNATE_EVENT_REGISTER), 32'h7);
		usbn_host_mdl_i.set_line(`USBN_LS_K);
		repeat (4) @(posedge clk_i);
		rd_chk(ra(`USBN_A_ALTERNATE_EVENT_REGISTER), 32'h2, 32'h2);
		chk_pin(9'(n_wake), 9'h1);
		usbn_host_mdl_i.set_line(`USBN_LS_J);
		repeat (SUSP + 5) @(posedge clk_i);
		wr(ra(`USBN_A_NODE_FUNCTIONAL_STATE_REGISTER), 32'h2);
		repeat (3) @(posedge clk_i);
		chk_pin({oen, dpo, dmo}, 9'h1);
		repeat (RESK + 2) @(posedge clk_i);
		wr(ra(`USBN_A_NODE_FUNCTIONAL_STATE_REGISTER), 32'h1);
		wr(ra(`USBN_A_NODE_FUNCTIONAL_STATE_REGISTER), 32'h2);
		repeat (3) @(posedge clk_i);
		chk_pin({run, oen, dpo, dmo}, 9'h9);
		repeat (RESK + 2) @(posedge clk_i);
		wr(ra(`USBN_A_NODE_FUNCTIONAL_STATE_REGISTER), 32'h0);
		usbn_host_mdl_i.set_line(`USBN_LS_SE0);
		repeat (30) @(posedge clk_i);
		usbn_host_mdl_i.set_line(`USBN_LS_J);
		rd_chk(ra(`USBN_A_ALTERNATE_EVENT_REGISTER), 32'h4, 32'h4);
		rd_chk(ra(`USBN_A_NODE_FUNCTIONAL_STATE_REGISTER), 32'h3, 32'h3);
		wr(ra(`USBN_A_NODE_FUNCTIONAL_STATE_REGISTER), 32'h0);
		function_address_register = 7'($random(seed)) | 7'h1;
		wr(ra(`USBN_A_FUNCTION_ADDRESS_REGISTER), {25'h0, function_address_register});
		rd_chk(ra(`USBN_A_FUNCTION_ADDRESS_REGISTER), 32'h7f, {25'h0, function_address_register});
		for (int r = 0; r < 3; r++) begin
			n = 1 + int'($unsigned($random(seed)) % 8);
			err = (r == 2);
			for (int i = 0; i < 8; i++) usbn_host_mdl_i.pkt[i] = 8'($random(seed));
			wr(ra(`USBN_A_EP0C), 32'ha);
			usbn_host_mdl_i.token(`USBN_PID_OUT, function_address_register, 4'h0, hit);
			chk_pin({8'h0, hit}, 9'h1);
			usbn_host_mdl_i.out_pkt(n, err);
			rd_chk(ra(`USBN_A_EP0S), '1, ep0_stat(n, err));
			for (int i = 0; i < n && !err; i++)
				rd_chk(ra(`USBN_A_EP0D), 32'hff, {24'h0, usbn_host_mdl_i.pkt[i]});
		end
		usbn_host_mdl_i.token(`USBN_PID_OUT, function_address_register ^ 7'h40, 4'h0, hit);
		chk_pin({8'h0, hit}, 9'h0);
		wr(ra(`USBN_A_EP0C), 32'h6);
		usbn_host_mdl_i.token(`USBN_PID_SETUP, 7'h0, 4'h0, hit);
		chk_pin({8'h0, hit}, 9'h1);
		usbn_host_mdl_i.out_pkt(1, 1'b0);
		wr(ra(`USBN_A_EP0C), 32'h9);
		for (int i = 0; i < 8; i++) wr(ra(`USBN_A_EP0D), {24'h0, usbn_host_mdl_i.pkt[i]});
		wr(ra(`USBN_A_EP0C), 32'h11);
		for (int r = 0; r < 2; r++) begin
			usbn_host_mdl_i.token(`USBN_PID_IN, function_address_register, 4'h0, hit);
			usbn_host_mdl_i.in_pkt(8, r[0]);
			for (int i = 0; i < 8; i++)
				chk_pin(usbn_host_mdl_i.got[i], {1'b1, usbn_host_mdl_i.pkt[i]});
		end
		rd_chk(ra(`USBN_A_EP0S), '1, 32'h82);
		e = 4'($random(seed)) | 4'h1;
		for (int p = 1; p <= 4; p++) wr(pa(p, 8'h0), {27'h0, 1'b1, e});
		usbn_host_mdl_i.token(`USBN_PID_OUT, function_address_register, e, hit);
		usbn_host_mdl_i.out_pkt(3, 1'b0);
		rd_chk(pa(2, 8'h4), 32'hff, 32'h83);
		rd_chk(pa(4, 8'h4), 32'hff, 32'h0);
		rd_chk(pa(2, 8'h8), 32'hff, {24'h0, usbn_host_mdl_i.pkt[0]});
		wr(pa(1, 8'h8), {24'h0, usbn_host_mdl_i.pkt[1]});
		usbn_host_mdl_i.token(`USBN_PID_IN, function_address_register, e, hit);
		usbn_host_mdl_i.in_pkt(2, 1'b1);
		chk_pin(usbn_host_mdl_i.got[0], {1'b1, usbn_host_mdl_i.pkt[1]});
		chk_pin({8'h0, usbn_host_mdl_i.got[1][8]}, 9'h0);
		rd_chk(8'hfc, '1, 32'h0);
		wr(ra(`USBN_A_MAIN), 32'h0);
		repeat (2) @(posedge clk_i);
		chk_pin({run, oen, dpo, dmo}, 9'h0);
		wr(ra(`USBN_A_MAIN), 32'h1);
		rd_chk(ra(`USBN_A_FUNCTION_ADDRESS_REGISTER), '1, 32'h0);
		report_and_stop();
	end
endmodule // tb_usbn_node

// ---- tb/usbn_host_mdl.sv ----
// usbn_host_mdl.sv: host and serial engine model facing the node
// assumes the bench calls its tasks from one process, clk_i at 10 MHz
`timescale 1ns/1ps

module usbn_host_mdl (
	input  wire        clk_i,
	input  wire        tok_hit_i,
	input  wire [7:0]  tx_byte_i,
	input  wire        tx_vld_i,
	output logic       dp_o = 1'b1,
	output logic       dm_o = 1'b0,
	output logic       tok_valid_o = 1'b0,
	output logic [1:0] tok_pid_o = 2'h3,
	output logic [10:0] tok_bits_o = 11'h0,
	output logic       rx_vld_o = 1'b0,
	output logic [7:0] rx_byte_o = 8'h0,
	output logic       rx_end_o = 1'b0,
	output logic       rx_err_o = 1'b0,
	output logic       tx_req_o = 1'b0,
	output logic       tx_end_o = 1'b0,
	output logic       tx_ok_o = 1'b0
);
	logic [7:0] pkt [0:7];
	logic [8:0] got [0:7];

	task automatic set_line(input logic [1:0] ls);
		@(posedge clk_i);
		{dp_o, dm_o} <= ls;
	endtask

	task automatic token(input logic [1:0] pid, input logic [6:0] adr,
		input logic [3:0] ep, output logic hit);
		@(posedge clk_i);
		tok_valid_o <= 1'b1;
		tok_pid_o <= pid;
		tok_bits_o <= {ep, adr};
		@(posedge clk_i);
		tok_valid_o <= 1'b0;
		tok_bits_o <= ~{ep, adr};
		@(posedge clk_i);
		hit = tok_hit_i;
	endtask

	task automatic out_pkt(input int n, input logic err);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			rx_vld_o <= 1'b1;
			rx_byte_o <= pkt[i];
			@(posedge clk_i);
			rx_vld_o <= 1'b0;
			rx_byte_o <= ~pkt[i];
		end
		@(posedge clk_i);
		rx_end_o <= 1'b1;
		rx_err_o <= err;
		@(posedge clk_i);
		rx_end_o <= 1'b0;
		rx_err_o <= 1'b0;
	endtask

	task automatic in_pkt(input int n, input logic ok);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			tx_req_o <= 1'b1;
			@(posedge clk_i);
			tx_req_o <= 1'b0;
			@(posedge clk_i);
			got[i] = {tx_vld_i, tx_byte_i};
		end
		@(posedge clk_i);
		tx_end_o <= 1'b1;
		tx_ok_o <= ok;
		@(posedge clk_i);
		tx_end_o <= 1'b0;
		tx_ok_o <= ~ok;
	endtask
endmodule // usbn_host_mdl

// ---- tb/usbn_node_properties.sv ----
// usbn_node_properties.sv: port-level checks on the usb node
// assumes bind to usbn_node, one clock domain, sync active-high rst_i
`timescale 1ns/1ps
`include "usbn_consts.vh"

module usbn_node_props #(
	parameter [15:0] SUSP_CYC  = 16'd50,
	parameter [15:0] RES_K_CYC = 16'd20
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire wb_ack_o,
	input wire wakeup_o,
	input wire clk48_run_o,
	input wire dp_i,
	input wire dm_i,
	input wire dp_o,
	input wire dm_o,
	input wire line_oe_n_o,
	input wire tok_valid_i,
	input wire tok_hit_o,
	input wire rx_end_i,
	input wire tx_end_i,
	input wire tx_req_i,
	input wire tx_vld_o,
	input wire tx_none_o
);
	reg        run_d_r;
	reg [15:0] k_cnt_r;
	wire       kd = run_d_r & clk48_run_o & ~line_oe_n_o;

	// length of the current stretch of driven resume signalling
	always @(posedge clk_i) begin
		if (rst_i) begin
			run_d_r <= 1'b0;
			k_cnt_r <= 16'h0;
		end else begin
			run_d_r <= clk48_run_o;
			k_cnt_r <= kd ? k_cnt_r + 16'h1 : 16'h0;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack1;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	AST_ACK_ONE: assert property (s_req |=> s_ack1)
		else $error("ack not a single pulse one cycle after request");
	AST_RUN_BY_WRITE: assert property ($changed(clk48_run_o) |->
		wb_ack_o && $past(wb_we_i)) else $error("enable moved without write");
	AST_SE0_OFF: assert property (!clk48_run_o && $past(!clk48_run_o)
		|-> !line_oe_n_o && !dp_o && !dm_o) else $error("no SE0 when off");
	AST_K_DRIVE: assert property (kd |-> !dp_o && dm_o)
		else $error("driven line is not K");
	AST_K_LEN: assert property ($fell(kd) && clk48_run_o |->
		k_cnt_r == RES_K_CYC) else $error("resume K length wrong");
	AST_WAKE_CAUSE: assert property (wakeup_o |->
		$past({dp_i, dm_i}, 2) == `USBN_LS_J && $past({dp_i, dm_i}) !=
		`USBN_LS_J) else $error("wake-up without activity after idle");
	AST_WAKE_PULSE: assert property (wakeup_o |=> !wakeup_o)
		else $error("wake-up longer than one cycle");
	AST_HIT_CAUSE: assert property ($rose(tok_hit_o) |->
		$past(tok_valid_i)) else $error("hit without token");
	AST_HIT_HOLD: assert property (tok_hit_o && !rx_end_i && !tx_end_i
		|=> tok_hit_o || !clk48_run_o) else $error("hit dropped early");
	AST_TX_ANSWER: assert property (tx_req_i && tok_hit_o |=>
		tx_vld_o ^ tx_none_o) else $error("byte request unanswered");
	AST_TX_CAUSE: assert property (tx_vld_o || tx_none_o |->
		$past(tx_req_i)) else $error("byte answer without request");
endmodule // usbn_node_props

bind usbn_node usbn_node_props #(.SUSP_CYC(SUSP_CYC), .RES_K_CYC(RES_K_CYC))
	usbn_node_props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
	.wakeup_o(wakeup_o), .clk48_run_o(clk48_run_o), .dp_i(dp_i),
	.dm_i(dm_i), .dp_o(dp_o), .dm_o(dm_o), .line_oe_n_o(line_oe_n_o),
	.tok_valid_i(tok_valid_i), .tok_hit_o(tok_hit_o), .rx_end_i(rx_end_i),
	.tx_end_i(tx_end_i), .tx_req_i(tx_req_i), .tx_vld_o(tx_vld_o),
	.tx_none_o(tx_none_o));
